/* File: core/cbtc_pkg.sv */
// Constants for the CAN bit-timing configuration block.
// Assumes a single system clock that also clocks the CAN controller.
package cbtc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ----------------------------------------------------------------
    localparam logic [11:0] CBTC_OFS_TIMING = 12'h000; // bit_timing_config
    localparam logic [11:0] CBTC_OFS_CTRL   = 12'h004; // Mode control
    localparam logic [11:0] CBTC_OFS_STATUS = 12'h008; // Engine status

    // ----------------------------------------------------------------
    // bit_timing_config field layout
    // ----------------------------------------------------------------
    localparam int CBTC_PRESC_LSB = 16;
    localparam int CBTC_PRESC_MSB = 23;
    localparam int CBTC_SJW_LSB   = 8;
    localparam int CBTC_SJW_MSB   = 9;
    localparam int CBTC_TSAM_BIT  = 7;
    localparam int CBTC_PHASE_ONE_LENGTH_LSB = 3;
    localparam int CBTC_PHASE_ONE_LENGTH_MSB = 6;
    localparam int CBTC_PHASE_TWO_LENGTH_LSB = 0;
    localparam int CBTC_PHASE_TWO_LENGTH_MSB = 2;

    // Control register fields
    localparam int CBTC_CTRL_INIT_BIT = 0;
    localparam int CBTC_CTRL_PROT_BIT = 1;

    // Status register fields
    localparam int CBTC_STAT_BIT_BIT = 0;
    localparam int CBTC_STAT_SEG_LSB = 1;
    localparam int CBTC_STAT_SEG_MSB = 2;
    localparam int CBTC_STAT_RX_BIT  = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CBTC_RST_PRESC = 8'h00;
    localparam logic [1:0] CBTC_RST_SJW   = 2'h0;
    localparam logic       CBTC_RST_TSAM  = 1'b0;
    localparam logic [3:0] CBTC_RST_PHASE_ONE_LENGTH = 4'h0;
    localparam logic [2:0] CBTC_RST_PHASE_TWO_LENGTH = 3'h0;
    localparam logic       CBTC_RST_INIT  = 1'b1;
    localparam logic       CBTC_RST_PROT  = 1'b0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CBTC_CLK_PERIOD_NS = 100; // System clock, 10 MHz

    // Bit segments
    typedef enum logic [1:0] {
        CBTC_SEG_SYNC,
        CBTC_SEG_PH1,
        CBTC_SEG_PH2
    } cbtc_seg_e;

endpackage : cbtc_pkg

/* File: core/cbtc_top.sv */
// CAN bit-timing configuration and bit segmentation, APB slave.
// Assumes CAN_RX_I is asynchronous; APB runs on CLK_SYS_I.
//
// Operation
// - Timing register writes ignored outside initialization mode.
// - Timing writes need protected write enable and init mode; reads always.
// - Quantum equals clock period times prescaler value plus one, bits 23:16.
// - Effective prescaler is stored value plus one, 1 to 256.
// - Jump width from bits 9:8 plus one, 1 to 4 quanta.
// - Resync lengthens or shortens bit by at most jump width.
// - Reserved bits 31:24 and 15:10 ignore writes.
// - Prescaler clocked at system clock rate.
// - Bit 7 selects three-sample majority ending at sample point.
// - Phase-one length is bits 6:3 plus one.
// - Phase-two length is bits 2:0 plus one, 1 to 8.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module cbtc_top
    import cbtc_pkg::*;
#(
    parameter int PRESC_W = 8
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        CAN_RX_I,
    output logic             SAMPLE_BIT_O,
    output logic             SAMPLE_STROBE_O,
    output logic             TQ_TICK_O
);

    // --------------------------------------------------------------
    // Parameter check
    // --------------------------------------------------------------
    // Refuse any width other than the 8 bits the register layout holds
    if (PRESC_W != 8) begin : g_presc_chk
        $error("PRESC_W must be 8");
    end

    typedef struct packed {
        logic [7:0] presc;
        logic [1:0] resync_jump_width;
        logic       tsam;
        logic [3:0] phase_one_length;
        logic [2:0] phase_two_length;
        logic       init_mode;
        logic       prot_en;
        cbtc_seg_e  seg;
        logic [4:0] q_cnt;
        logic [4:0] seg_len;
        logic       rx_meta;
        logic       rx_sync;
        logic       rx_prev;
        logic [1:0] hist;
        logic       smp_bit;
        logic       smp_stb;
        logic       tq_tick;
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
    } cbtc_state_s;

    cbtc_state_s st_r;
    cbtc_state_s st_nxt;

    cbtc_tq_if #(.PRESC_W(PRESC_W)) tq_if ();

    // Prescaler feed
    assign tq_if.presc_val = st_r.presc;
    assign tq_if.run       = ~st_r.init_mode;

    cbtc_tq_prescaler #(.PRESC_W(PRESC_W)) u_presc (
        .clk_i (CLK_SYS_I),
        .rst_i (RST_I),
        .tq    (tq_if.gen)
    );

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb begin
        logic [4:0] ph1_len;
        logic [4:0] ph2_len;
        logic [4:0] sjw_eff;
        logic [4:0] q1;
        logic [4:0] len;
        logic       edge_seen;
        logic       maj;
        logic       acc;
        logic       hit;
        logic [31:0] rd;
        st_nxt = st_r;
        ph1_len = {1'b0, st_r.phase_one_length} + 5'h01;
        ph2_len = {2'b00, st_r.phase_two_length} + 5'h01;
        sjw_eff = {3'b000, st_r.resync_jump_width} + 5'h01;
        q1 = st_r.q_cnt + 5'h01;
        len = st_r.seg_len;
        edge_seen = tq_if.tick & st_r.rx_prev & ~st_r.rx_sync;
        maj = (st_r.hist[1] & st_r.hist[0]) | (st_r.hist[1] & st_r.rx_sync)
            | (st_r.hist[0] & st_r.rx_sync);
        acc = PSEL_I & PENABLE_I;
        hit = 1'b1;
        rd = 32'h0000_0000;

        // Receive synchroniser
        st_nxt.rx_meta = CAN_RX_I;
        st_nxt.rx_sync = st_r.rx_meta;
        st_nxt.smp_stb = 1'b0;
        st_nxt.tq_tick = tq_if.tick;

        // Bit segmentation
        if (st_r.init_mode) begin
            st_nxt.seg     = CBTC_SEG_SYNC;
            st_nxt.q_cnt   = 5'h00;
            st_nxt.seg_len = 5'h01;
        end else if (tq_if.tick) begin
            st_nxt.rx_prev = st_r.rx_sync;
            st_nxt.hist    = {st_r.hist[0], st_r.rx_sync};
            st_nxt.q_cnt   = q1;
            unique case (st_r.seg)
                CBTC_SEG_SYNC: begin
                    st_nxt.seg     = CBTC_SEG_PH1;
                    st_nxt.q_cnt   = 5'h00;
                    st_nxt.seg_len = ph1_len;
                end
                CBTC_SEG_PH1: begin
                    // lengthen by at most jump width
                    if (edge_seen) begin
                        len = st_r.seg_len + ((q1 < sjw_eff) ? q1 : sjw_eff);
                    end
                    st_nxt.seg_len = len;
                    // sample at end of phase one
                    if (q1 >= len) begin
                        st_nxt.smp_stb = 1'b1;
                        st_nxt.smp_bit = st_r.tsam ? maj : st_r.rx_sync;
                        st_nxt.seg     = CBTC_SEG_PH2;
                        st_nxt.q_cnt   = 5'h00;
                        st_nxt.seg_len = ph2_len;
                    end
                end
                CBTC_SEG_PH2: begin
                    // shorten by at most jump width
                    if (edge_seen) begin
                        len = (ph2_len > sjw_eff + q1) ? ph2_len - sjw_eff : q1;
                    end
                    st_nxt.seg_len = len;
                    if (q1 >= len) begin
                        st_nxt.seg     = CBTC_SEG_SYNC;
                        st_nxt.q_cnt   = 5'h00;
                        st_nxt.seg_len = 5'h01;
                    end
                end
            endcase
        end

        // APB read mux, reserved bits read zero
        unique case (PADDR_I)
            CBTC_OFS_TIMING: begin
                rd[CBTC_PRESC_MSB:CBTC_PRESC_LSB] = st_r.presc;
                rd[CBTC_SJW_MSB:CBTC_SJW_LSB]     = st_r.resync_jump_width;
                rd[CBTC_TSAM_BIT]                 = st_r.tsam;
                rd[CBTC_PHASE_ONE_LENGTH_MSB:CBTC_PHASE_ONE_LENGTH_LSB] = st_r.phase_one_length;
                rd[CBTC_PHASE_TWO_LENGTH_MSB:CBTC_PHASE_TWO_LENGTH_LSB] = st_r.phase_two_length;
            end
            CBTC_OFS_CTRL: begin
                rd[CBTC_CTRL_INIT_BIT] = st_r.init_mode;
                rd[CBTC_CTRL_PROT_BIT] = st_r.prot_en;
            end
            CBTC_OFS_STATUS: begin
                rd[CBTC_STAT_BIT_BIT]             = st_r.smp_bit;
                rd[CBTC_STAT_SEG_MSB:CBTC_STAT_SEG_LSB] = st_r.seg;
                rd[CBTC_STAT_RX_BIT]              = st_r.rx_sync;
            end
            default: hit = 1'b0;
        endcase

        // APB: one wait state, answer registered
        st_nxt.pready  = acc & ~st_r.pready;
        st_nxt.pslverr = acc & ~st_r.pready & ~hit;
        if (acc & ~st_r.pready & ~PWRITE_I) begin
            st_nxt.prdata = rd;
        end

        // Register writes at completing edge
        if (acc & st_r.pready & PWRITE_I) begin
            if (PADDR_I == CBTC_OFS_TIMING && st_r.init_mode && st_r.prot_en) begin
                st_nxt.presc = PWDATA_I[CBTC_PRESC_MSB:CBTC_PRESC_LSB];
                st_nxt.resync_jump_width   = PWDATA_I[CBTC_SJW_MSB:CBTC_SJW_LSB];
                st_nxt.tsam  = PWDATA_I[CBTC_TSAM_BIT];
                st_nxt.phase_one_length = PWDATA_I[CBTC_PHASE_ONE_LENGTH_MSB:CBTC_PHASE_ONE_LENGTH_LSB];
                st_nxt.phase_two_length = PWDATA_I[CBTC_PHASE_TWO_LENGTH_MSB:CBTC_PHASE_TWO_LENGTH_LSB];
            end
            if (PADDR_I == CBTC_OFS_CTRL) begin
                st_nxt.init_mode = PWDATA_I[CBTC_CTRL_INIT_BIT];
                st_nxt.prot_en   = PWDATA_I[CBTC_CTRL_PROT_BIT];
            end
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            st_r           <= '0;
            st_r.presc     <= CBTC_RST_PRESC;
            st_r.resync_jump_width       <= CBTC_RST_SJW;
            st_r.tsam      <= CBTC_RST_TSAM;
            st_r.phase_one_length     <= CBTC_RST_PHASE_ONE_LENGTH;
            st_r.phase_two_length     <= CBTC_RST_PHASE_TWO_LENGTH;
            st_r.init_mode <= CBTC_RST_INIT;
            st_r.prot_en   <= CBTC_RST_PROT;
            st_r.seg       <= CBTC_SEG_SYNC;
            st_r.seg_len   <= 5'h01;
            st_r.rx_meta   <= 1'b1;
            st_r.rx_sync   <= 1'b1;
            st_r.rx_prev   <= 1'b1;
            st_r.hist      <= 2'h3;
            st_r.smp_bit   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign PRDATA_O        = st_r.prdata;
    assign PREADY_O        = st_r.pready;
    assign PSLVERR_O       = st_r.pslverr;
    assign SAMPLE_BIT_O    = st_r.smp_bit;
    assign SAMPLE_STROBE_O = st_r.smp_stb;
    assign TQ_TICK_O       = st_r.tq_tick;

endmodule : cbtc_top

/* File: core/cbtc_tq_if.sv */
// Link between the bit-timing top and its quantum prescaler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface cbtc_tq_if #(parameter int PRESC_W = 8);
    logic [PRESC_W-1:0] presc_val; // Stored prescaler value
    logic               run;       // Engine running
    logic               tick;      // One-cycle pulse per quantum

    modport gen (input presc_val, input run, output tick);
    modport use_tq (output presc_val, output run, input tick);
endinterface : cbtc_tq_if

/* File: core/cbtc_tq_prescaler.sv */
// Time-quantum prescaler: one tick every (presc_val + 1) system clocks.
// Assumes presc_val stable while run is high.
`timescale 1ns/1ps
module cbtc_tq_prescaler
    import cbtc_pkg::*;
#(
    parameter int PRESC_W = 8
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    cbtc_tq_if.gen      tq
);

    typedef struct packed {
        logic [PRESC_W-1:0] cnt;
        logic               tick;
    } cbtc_presc_s;

    cbtc_presc_s st_r;
    cbtc_presc_s st_nxt;

    // --------------------------------------------------------------
    // Divider
    // --------------------------------------------------------------
    // Count clocks, wrap at prescaler value
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!tq.run) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == tq.presc_val) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + PRESC_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tq.tick = st_r.tick;

endmodule : cbtc_tq_prescaler

/* File: verif/cbtc_can_node.sv */
// Stand-in for the CAN network driving the block's receive line.
// Assumes a terminated bus: recessive (1) whenever no node drives.
`timescale 1ns/1ps
module cbtc_can_node (
    input  wire logic clk_i,
    output logic      rx_o
);
    initial rx_o = 1'b1;

    // Drive a bus level after a delay in clocks, prompt or slow
    task drive(input logic lvl, input int dly);
        repeat (dly) @(posedge clk_i);
        rx_o <= lvl;
    endtask : drive
endmodule : cbtc_can_node

/* File: verif/cbtc_monitor.sv */
// Checker for the bit-timing block, seeing only the top-level ports.
// Assumes it is bound onto cbtc_top and that all ports share CLK_SYS_I.
`timescale 1ns/1ps
module cbtc_monitor
    import cbtc_pkg::*;
(
    input wire logic        CLK_SYS_I,
    input wire logic        RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        CAN_RX_I,
    input wire logic        SAMPLE_BIT_O,
    input wire logic        SAMPLE_STROBE_O,
    input wire logic        TQ_TICK_O
);
    // ----------------------------------------------------------------
    // Bus and bit-timing properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    logic map_hit;

    // Address falls on one of the three registers
    assign map_hit = PADDR_I inside {CBTC_OFS_TIMING, CBTC_OFS_CTRL, CBTC_OFS_STATUS};

    // First access cycle, then completion
    sequence s_first;
        PSEL_I && PENABLE_I && !$past(PENABLE_I);
    endsequence
    sequence s_done;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence

    chk_access_wait: assert property (s_first |-> !PREADY_O ##1 PREADY_O)
        else $error("ready not one cycle after access start");
    chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    chk_idle_ready: assert property (!PSEL_I |-> !PREADY_O)
        else $error("ready without select");
    chk_err_unmapped: assert property ((s_done and !map_hit) |-> PSLVERR_O)
        else $error("no error on unmapped address");
    chk_err_mapped: assert property ((s_done and map_hit) |-> !PSLVERR_O)
        else $error("error on mapped address");
    chk_rsvd_read: assert property (
        (s_done and (!PWRITE_I && PADDR_I == CBTC_OFS_TIMING))
        |-> (PRDATA_O & 32'hFF00FC00) == 32'h0)
        else $error("reserved timing bits read nonzero");
    chk_strobe_tick: assert property (SAMPLE_STROBE_O |-> TQ_TICK_O)
        else $error("sample strobe off a quantum tick");
    chk_strobe_spacing: assert property (SAMPLE_STROBE_O |=> !SAMPLE_STROBE_O [*2])
        else $error("sample strobes too close");
    chk_bit_strobe: assert property ($changed(SAMPLE_BIT_O) |-> SAMPLE_STROBE_O)
        else $error("sampled bit changed off the sample point");
endmodule : cbtc_monitor

/* File: verif/tb_top.sv */
// Self-checking bench for cbtc_top with a register model and a bus node.
// Assumes a 10 MHz system clock and PRESC_W of 8.
`timescale 1ns/1ps
module tb_top;
    import cbtc_pkg::*;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready, pslverr, rx, sbit, sstb, tick;
    int          bad_count, tests_run, cyc, seed, p, t1, t2, sj;
    logic [31:0] m_timing, q, c, nom, tq, cfg;
    logic        m_init, m_prot, e;

    always #50 clk = ~clk;

    cbtc_top #(.PRESC_W(8)) u_cbtc_top (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CAN_RX_I(rx),
        .SAMPLE_BIT_O(sbit), .SAMPLE_STROBE_O(sstb), .TQ_TICK_O(tick));
    cbtc_can_node u_cbtc_can_node (.clk_i(clk), .rx_o(rx));

    // ----------------------------------------------------------------
    // Compare, bus and timing tasks
    // ----------------------------------------------------------------
    task check32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task close_out;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // One APB transfer, checked against the register model
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check32({31'h0, e}, {31'h0, !(a inside {12'h000, 12'h004, 12'h008})});
        if (!w && a != CBTC_OFS_STATUS)
            check32(q, a == 12'h000 ? m_timing :
                a == 12'h004 ? {30'h0, m_prot, m_init} : 32'h0);
        if (w && a == CBTC_OFS_TIMING && m_init && m_prot) m_timing = d & 32'h00FF03FF;
        if (w && a == CBTC_OFS_CTRL) begin
            m_init = d[0];
            m_prot = d[1];
        end
    endtask : acc

    // Clocks up to the next tick or strobe, count left in c
    task gap(input logic s);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((s ? sstb : tick) !== 1'b1 && c < 5000);
    endtask : gap

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bad_count, tests_run, cyc} = '0;
        seed = 64634;
        {m_timing, m_init, m_prot} = {32'h0, 1'b1, 1'b0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, CBTC_OFS_TIMING, 32'h0);
        acc(1'b0, CBTC_OFS_CTRL, 32'h0);
        acc(1'b1, CBTC_OFS_TIMING, $random(seed));
        acc(1'b1, CBTC_OFS_CTRL, 32'h3);
        acc(1'b1, CBTC_OFS_TIMING, $random(seed));
        acc(1'b0, CBTC_OFS_TIMING, 32'h0);
        acc(1'b1, 12'hFFC, $random(seed));
        acc(1'b0, 12'h00D, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            sj = i;
            t2 = (i > 0 ? i : 1) + $unsigned($random(seed)) % (8 - (i > 0 ? i : 1));
            t1 = t2 + $unsigned($random(seed)) % (16 - t2);
            p = 5 + $unsigned($random(seed)) % 16;
            cfg = {8'h0, p[7:0], 6'h0, sj[1:0], i[0], t1[3:0], t2[2:0]};
            tq = p + 1;
            nom = (3 + t1 + t2) * tq;
            acc(1'b1, CBTC_OFS_TIMING, cfg);
            acc(1'b1, CBTC_OFS_CTRL, 32'h2);
            gap(1'b0);
            gap(1'b0);
            check32(c, tq);
            acc(1'b1, CBTC_OFS_TIMING, ~cfg);
            acc(1'b0, CBTC_OFS_TIMING, 32'h0);
            gap(1'b1);
            u_cbtc_can_node.drive(1'b0, 0);
            gap(1'b1);
            check32({31'h0, c >= nom - (sj + 2) * tq && c <= nom}, 32'h1);
            check32({31'h0, sbit}, 32'h0);
            u_cbtc_can_node.drive(1'b1, 0);
            gap(1'b1);
            check32(c, nom);
            check32({31'h0, sbit}, 32'h1);
            // edge in first phase-one quantum lengthens the bit by one quantum
            u_cbtc_can_node.drive(1'b0, (t2 + 2) * tq - 1);
            gap(1'b1);
            check32(c, nom + 1 - (t2 + 1) * tq);
            check32({31'h0, sbit}, 32'h0);
            u_cbtc_can_node.drive(1'b1, 0);
            acc(1'b1, CBTC_OFS_CTRL, 32'h3);
            $display("test timing %0d done", i);
        end
        close_out();
    end
endmodule : tb_top

bind cbtc_top cbtc_monitor u_cbtc_monitor (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .CAN_RX_I(CAN_RX_I), .SAMPLE_BIT_O(SAMPLE_BIT_O), .SAMPLE_STROBE_O(SAMPLE_STROBE_O),
    .TQ_TICK_O(TQ_TICK_O));
